// [core/fifo_bank_map.svh]
// Constants for the single-clock FIFO bank: widths, indices, settle count
`ifndef FIFO_BANK_MAP_SVH
`define FIFO_BANK_MAP_SVH

`define DATA_W 18
`define OFS_W 12
`define CMP_W 14
`define OFS_EMPTY 1'b0
`define OFS_FULL 1'b1
`define CFG_SETTLE 2'h3
`define SETTLE_STEP 2'h1
`define STRAP_FL 2
`define STRAP_RXI 1
`define STRAP_WXI 0
`define PF_RESET 3'h3

`endif

// [core/fifo_bank_pkg.sv]
// Types shared by the FIFO bank design
package fifo_bank_pkg;

   // Configuration caught from the strap pins after reset
   typedef struct packed
   {
      logic fall_through_mode;
      logic dbl;
      logic sync_pf;
   } mode_cfg_t;

   // Partial flag levels, all active low
   typedef struct packed
   {
      logic ae_n;
      logic af_n;
      logic hf_n;
   } part_flags_t;

endpackage

// [core/fifo_bank.sv]
// FIFO bank: storage buffer, flag logic, offset registers and output register
`timescale 1ns/1ps
`include "fifo_bank_map.svh"

////////////////////////////////////////////////////////////////////////////////

module sync_store
#(
   parameter int W = 18,
   parameter int DEPTH = 256
)
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_reg;
   logic [AW-1:0] wptr_next;
   logic [AW-1:0] rptr_reg;
   logic [AW-1:0] rptr_next;
   logic [AW:0] level_reg;
   logic [AW:0] level_next;
   logic push;
   logic pop;

   assign in_ready = (level_reg != (AW+1)'(DEPTH));
   assign out_valid = (level_reg != '0);
   assign out_data = mem[rptr_reg];
   assign level = level_reg;
   assign push = in_valid && in_ready;
   assign pop = out_ready && out_valid;

   always_comb
   begin
      // Power-of-two depth lets the pointers wrap on their own
      wptr_next = push ? wptr_reg + AW'(1) : wptr_reg;
      rptr_next = pop ? rptr_reg + AW'(1) : rptr_reg;
      level_next = level_reg + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         level_reg <= '0;
      end
      else
      begin
         wptr_reg <= wptr_next;
         rptr_reg <= rptr_next;
         level_reg <= level_next;
      end
   end

   // Storage has no reset so it maps onto plain RAM
   always_ff @(posedge clock)
   begin
      if (push)
      begin
         mem[wptr_reg] <= in_data;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////

module fifo_bank
#(
   parameter int DEPTH = 256,
   parameter logic [11:0] EMPTY_DEFAULT = 12'h01f,
   parameter logic [11:0] FULL_DEFAULT = 12'h01f
)
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic first_load_sel,
   input wire logic read_chain_in,
   input wire logic write_chain_in,
   input wire logic [17:0] write_data,
   input wire logic write_en_n,
   input wire logic read_en_n,
   input wire logic output_en_n,
   input wire logic offset_load_n,
   output logic [17:0] read_data,
   output logic read_data_en,
   output logic full_flag_n,
   output logic empty_flag_n,
   output logic almost_empty_n,
   output logic almost_full_n,
   output logic half_full_n
);
   localparam int AW = $clog2(DEPTH);

   logic [2:0] strap_s1_reg;
   logic [2:0] strap_s2_reg;
   fifo_bank_pkg::mode_cfg_t cfg_reg;
   fifo_bank_pkg::mode_cfg_t cfg_next;
   logic [1:0] settle_reg;
   logic [1:0] settle_next;
   logic ne1_reg, ne1_next, ne2_reg, ne2_next;
   logic fu1_reg, fu1_next, fu2_reg, fu2_next;
   logic ov_reg, ov_next;
   logic [`DATA_W-1:0] out_reg;
   logic [`DATA_W-1:0] out_next;
   logic [`OFS_W-1:0] ofs_e_reg, ofs_e_next, ofs_f_reg, ofs_f_next;
   logic wsel_reg, wsel_next, rsel_reg, rsel_next;
   fifo_bank_pkg::part_flags_t pf_reg;
   fifo_bank_pkg::part_flags_t pf_next;
   fifo_bank_pkg::part_flags_t pf_raw;
   logic store_in_ready;
   logic mem_ne;
   logic [`DATA_W-1:0] store_data;
   logic [AW:0] level;
   logic full_shown, empty_shown_ne;
   logic push, std_pop, fw_pop, pop, readback, ofs_wr;
   logic [`CMP_W-1:0] words;
   logic [`CMP_W-1:0] cap;

   sync_store #(.W(`DATA_W), .DEPTH(DEPTH)) store
   (
      .clock(clock),
      .rst_b(rst_b),
      .in_valid(push),
      .in_ready(store_in_ready),
      .in_data(write_data),
      .out_valid(mem_ne),
      .out_ready(pop),
      .out_data(store_data),
      .level(level)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Straps are static pins; synchronise before decoding

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         strap_s1_reg <= 3'h0;
         strap_s2_reg <= 3'h0;
      end
      else
      begin
         strap_s1_reg <= {first_load_sel, read_chain_in, write_chain_in};
         strap_s2_reg <= strap_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Handshake terms

   assign full_shown = (cfg_reg.fall_through_mode || cfg_reg.dbl) ? fu2_reg : fu1_reg;
   assign empty_shown_ne = cfg_reg.dbl ? ne2_reg : ne1_reg;
   assign push = offset_load_n && !write_en_n && !full_shown;
   assign std_pop = !cfg_reg.fall_through_mode && offset_load_n && !read_en_n
      && empty_shown_ne && mem_ne;
   // Two stages on not-empty put the first word out on the third edge
   assign fw_pop = cfg_reg.fall_through_mode && mem_ne && ne2_reg
      && (!ov_reg || (offset_load_n && !read_en_n));
   assign pop = std_pop || fw_pop;
   assign readback = !offset_load_n && !read_en_n && !cfg_reg.fall_through_mode;
   assign ofs_wr = !offset_load_n && !write_en_n;
   assign words = `CMP_W'(level) + `CMP_W'(cfg_reg.fall_through_mode && ov_reg);
   assign cap = `CMP_W'(DEPTH) + `CMP_W'(cfg_reg.fall_through_mode);

   always_comb
   begin
      pf_raw.ae_n = !(words <= `CMP_W'(ofs_e_reg) + `CMP_W'(cfg_reg.fall_through_mode));
      pf_raw.af_n = !(words >= cap - `CMP_W'(ofs_f_reg));
      pf_raw.hf_n = !(words > `CMP_W'(DEPTH / 2) + `CMP_W'(cfg_reg.fall_through_mode));
   end

   ////////////////////////////////////////////////////////////////////////////
   // Core state

   always_comb
   begin
      cfg_next = cfg_reg;
      settle_next = settle_reg;
      if (settle_reg != `CFG_SETTLE)
      begin
         settle_next = settle_reg + `SETTLE_STEP;
         cfg_next.fall_through_mode = !strap_s2_reg[`STRAP_RXI] && strap_s2_reg[`STRAP_WXI];
         cfg_next.dbl = strap_s2_reg[`STRAP_RXI] && !strap_s2_reg[`STRAP_WXI];
         cfg_next.sync_pf = strap_s2_reg[`STRAP_FL]
            && !(strap_s2_reg[`STRAP_RXI] && strap_s2_reg[`STRAP_WXI]);
      end
      ne1_next = mem_ne;
      ne2_next = ne1_reg;
      fu1_next = !store_in_ready;
      fu2_next = fu1_reg;
      out_next = out_reg;
      ov_next = ov_reg;
      rsel_next = rsel_reg;
      if (pop)
      begin
         out_next = store_data;
      end
      else if (readback)
      begin
         out_next = {{(`DATA_W-`OFS_W){1'b0}},
            (rsel_reg == `OFS_FULL) ? ofs_f_reg : ofs_e_reg};
         rsel_next = !rsel_reg;
      end
      if (fw_pop)
      begin
         ov_next = 1'b1;
      end
      else if (cfg_reg.fall_through_mode && offset_load_n && !read_en_n)
      begin
         ov_next = 1'b0;
      end
      ofs_e_next = ofs_e_reg;
      ofs_f_next = ofs_f_reg;
      wsel_next = wsel_reg;
      if (ofs_wr)
      begin
         if (wsel_reg == `OFS_EMPTY)
         begin
            ofs_e_next = write_data[`OFS_W-1:0];
         end
         else
         begin
            ofs_f_next = write_data[`OFS_W-1:0];
         end
         wsel_next = !wsel_reg;
      end
      pf_next = pf_raw;
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cfg_reg <= '0;
         settle_reg <= 2'h0;
         ne1_reg <= 1'b0;
         ne2_reg <= 1'b0;
         fu1_reg <= 1'b0;
         fu2_reg <= 1'b0;
         ov_reg <= 1'b0;
         out_reg <= '0;
         ofs_e_reg <= EMPTY_DEFAULT;
         ofs_f_reg <= FULL_DEFAULT;
         wsel_reg <= `OFS_EMPTY;
         rsel_reg <= `OFS_EMPTY;
         pf_reg <= `PF_RESET;
      end
      else
      begin
         cfg_reg <= cfg_next;
         settle_reg <= settle_next;
         ne1_reg <= ne1_next;
         ne2_reg <= ne2_next;
         fu1_reg <= fu1_next;
         fu2_reg <= fu2_next;
         ov_reg <= ov_next;
         out_reg <= out_next;
         ofs_e_reg <= ofs_e_next;
         ofs_f_reg <= ofs_f_next;
         wsel_reg <= wsel_next;
         rsel_reg <= rsel_next;
         pf_reg <= pf_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs; async almost-empty and almost-full follow the count directly, half-full is always registered

   assign read_data = out_reg;
   assign read_data_en = !output_en_n;
   assign full_flag_n = cfg_reg.fall_through_mode ? fu2_reg : !full_shown;
   assign empty_flag_n = cfg_reg.fall_through_mode ? !ov_reg : empty_shown_ne;
   assign almost_empty_n = cfg_reg.sync_pf ? pf_reg.ae_n : pf_raw.ae_n;
   assign almost_full_n = cfg_reg.sync_pf ? pf_reg.af_n : pf_raw.af_n;
   assign half_full_n = pf_reg.hf_n;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   sequence s_first_write;
      cfg_reg.fall_through_mode && !ov_reg && level == '0 && push && store_in_ready;
   endsequence

   sequence s_fall_delay;
      !ov_reg [*3] ##1 ov_reg;
   endsequence

   // The load of the first word itself lands on the third edge
   property p_first_word;
      s_first_write |-> ##1 !pop [*2] ##1 pop;
   endproperty
   a_first_word: assert property (p_first_word)
      else $error("first word not shown on third read edge");

   property p_first_hidden;
      s_first_write |-> ##1 s_fall_delay;
   endproperty
   a_first_hidden: assert property (p_first_hidden)
      else $error("first word timing wrong");

   property p_wen_high;
      write_en_n |-> !push;
   endproperty
   a_wen_high: assert property (p_wen_high)
      else $error("write stored with enable high");

   property p_full_ignored;
      full_shown |-> !push;
   endproperty
   a_full_ignored: assert property (p_full_ignored)
      else $error("write accepted while full");

   property p_full_single;
      !cfg_reg.fall_through_mode && !cfg_reg.dbl && !store_in_ready |=> !full_flag_n;
   endproperty
   a_full_single: assert property (p_full_single)
      else $error("full flag late");

   property p_std_read;
      std_pop |=> out_reg == $past(store_data);
   endproperty
   a_std_read: assert property (p_std_read)
      else $error("read word not loaded");

   property p_hold;
      read_en_n && !cfg_reg.fall_through_mode |=> $stable(out_reg);
   endproperty
   a_hold: assert property (p_hold)
      else $error("output changed with read enable high");

   property p_empty_gate;
      !cfg_reg.fall_through_mode && !empty_flag_n |-> !pop;
   endproperty
   a_empty_gate: assert property (p_empty_gate)
      else $error("read while empty");

   property p_or_high;
      cfg_reg.fall_through_mode && ov_reg && offset_load_n && !read_en_n && !fw_pop |=> empty_flag_n;
   endproperty
   a_or_high: assert property (p_or_high)
      else $error("output ready did not go high");

   property p_ofs_step;
      ofs_wr && wsel_reg == `OFS_FULL |=> ofs_f_reg == $past(write_data[`OFS_W-1:0])
         && wsel_reg == `OFS_EMPTY;
   endproperty
   a_ofs_step: assert property (p_ofs_step)
      else $error("full offset write wrong");

   property p_ofs_idle;
      !offset_load_n && write_en_n |=> $stable(wsel_reg) && $stable(ofs_e_reg);
   endproperty
   a_ofs_idle: assert property (p_ofs_idle)
      else $error("offset changed with write enable high");

   property p_no_readback;
      cfg_reg.fall_through_mode && !offset_load_n |=> $stable(rsel_reg);
   endproperty
   a_no_readback: assert property (p_no_readback)
      else $error("offset read-back in fall-through mode");

   property p_almost_empty;
      !cfg_reg.fall_through_mode && !cfg_reg.sync_pf && words <= `CMP_W'(ofs_e_reg) |-> !almost_empty_n;
   endproperty
   a_almost_empty: assert property (p_almost_empty)
      else $error("almost-empty not low");
endmodule

// [tb/read_consumer.sv]
// Read-side consumer model for the FIFO bank
`timescale 1ns/1ps

////////////////////////////////////////////////////////////
module read_consumer
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic go,
   input wire logic slow,
   output logic read_en_n
);

   logic phase_reg;
   logic phase_next;

   always_comb
   begin
      phase_next = ~phase_reg;
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         phase_reg <= 1'b0;
      else
         phase_reg <= phase_next;
   end

   // Every word is asked for, the first too; slow stalls every other cycle
   assign read_en_n = !(go && (!slow || phase_reg));

endmodule

// [tb/fifo_bank_tb.sv]
// Self-checking bench for the FIFO bank with a scoreboard queue
`timescale 1ns/1ps

////////////////////////////////////////////////////////////
module fifo_bank_tb;

   localparam logic [2:0] CODES [4] = '{3'b000, 3'b100, 3'b010, 3'b110};
   logic clock = 1'b0;
   logic rst_b;
   logic first_load_sel;
   logic read_chain_in;
   logic write_chain_in;
   logic [17:0] write_data;
   logic write_en_n;
   logic read_en_n;
   logic output_en_n;
   logic offset_load_n;
   logic [17:0] read_data;
   logic read_data_en;
   logic full_flag_n;
   logic empty_flag_n;
   logic almost_empty_n;
   logic almost_full_n;
   logic half_full_n;
   logic go;
   logic slow;
   logic fall_through_mode_on;
   logic took;
   logic [17:0] w;
   logic [17:0] last_q;
   logic [17:0] exp_q[$];
   logic [31:0] seed_val = 32'h037a;
   int err_count;
   int tests_run;

   always #20 clock = ~clock;

   fifo_bank #(.DEPTH(256)) dut_u
   (
      .clock(clock),
      .rst_b(rst_b),
      .first_load_sel(first_load_sel),
      .read_chain_in(read_chain_in),
      .write_chain_in(write_chain_in),
      .write_data(write_data),
      .write_en_n(write_en_n),
      .read_en_n(read_en_n),
      .output_en_n(output_en_n),
      .offset_load_n(offset_load_n),
      .read_data(read_data),
      .read_data_en(read_data_en),
      .full_flag_n(full_flag_n),
      .empty_flag_n(empty_flag_n),
      .almost_empty_n(almost_empty_n),
      .almost_full_n(almost_full_n),
      .half_full_n(half_full_n)
   );

   read_consumer reader_u
   (
      .clock(clock),
      .rst_b(rst_b),
      .go(go),
      .slow(slow),
      .read_en_n(read_en_n)
   );

   ////////////////////////////////////////////////////////////
   function automatic logic [17:0] next_word();
      seed_val = {seed_val[30:0], seed_val[31] ^ seed_val[21] ^ seed_val[1] ^ seed_val[0]};
      return seed_val[17:0];
   endfunction

   task automatic check(input logic [17:0] got, input logic [17:0] exp);
   begin
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask

   task automatic complete_run;
   begin
      $display("Counts: tests_run=%0d err_count=%0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   end
   endtask

   task automatic end_test(input string name);
      $display("Test %s done at %0t", name, $time);
   endtask

   task automatic tick(input int n);
   begin
      repeat (n) @(posedge clock);
      #2;
   end
   endtask

   // Held until the next edge takes it; back to back calls write every cycle
   task automatic wr(input logic [17:0] d, input logic note);
   begin
      tick(1);
      write_en_n = 1'b0;
      write_data = d;
      if (note)
         exp_q.push_back(d);
   end
   endtask

   task automatic wr_end;
   begin
      tick(1);
      write_en_n = 1'b1;
   end
   endtask

   task automatic do_reset(input logic [2:0] s);
   begin
      rst_b = 1'b0;
      {first_load_sel, read_chain_in, write_chain_in} = s;
      exp_q.delete();
      tick(3);
      check(full_flag_n, 1'b1);
      check(empty_flag_n, 1'b0);
      check(almost_empty_n, 1'b0);
      check(almost_full_n, 1'b1);
      check(half_full_n, 1'b1);
      check(read_data, 18'h00000);
      output_en_n = 1'b1;
      tick(1);
      check(read_data_en, 1'b0);
      output_en_n = 1'b0;
      tick(7);
      check(read_data_en, 1'b1);
      rst_b = 1'b1;
      tick(5);
   end
   endtask

   task automatic drain(input logic pace);
   begin
      slow = pace;
      go = 1'b1;
      for (int i = 0; i < 600 && exp_q.size() > 0; i++)
         tick(1);
      go = 1'b0;
      slow = 1'b0;
      check(exp_q.size(), 18'h00000);
   end
   endtask

   ////////////////////////////////////////////////////////////
   // Scoreboard: a taken read shows its word by the falling edge
   always @(posedge clock)
   begin
      took = rst_b && !fall_through_mode_on && !read_en_n && (!offset_load_n || empty_flag_n)
         && exp_q.size() > 0;
   end

   always @(negedge clock)
   begin
      if (took === 1'b1)
         check(read_data, exp_q.pop_front());
      else if (rst_b === 1'b1 && fall_through_mode_on === 1'b0)
         check(read_data, last_q);
      last_q = read_data;
   end

   initial
   begin
      repeat (5000) @(posedge clock);
      err_count++;
      $display("[ERR] t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
      complete_run();
   end

   initial
   begin
      rst_b = 1'b0;
      {first_load_sel, read_chain_in, write_chain_in} = 3'b000;
      write_data = 18'h00000;
      write_en_n = 1'b1;
      output_en_n = 1'b0;
      offset_load_n = 1'b1;
      go = 1'b0;
      slow = 1'b0;
      fall_through_mode_on = 1'b0;
      last_q = 18'h00000;
      for (int i = 0; i < 4; i++)
      begin
         do_reset(CODES[i]);
         wr(next_word(), 1'b1);
         wr_end();
         check(empty_flag_n, 1'b0);
         tick(1);
         check(empty_flag_n, !CODES[i][1]);
         tick(1);
         check(empty_flag_n, 1'b1);
      end
      end_test("strap modes");
      // Offset reads never overlap offset writes: go stays low while loading
      do_reset(3'b000);
      offset_load_n = 1'b0;
      wr(18'h00005, 1'b0);
      wr_end();
      offset_load_n = 1'b1;
      tick(1);
      offset_load_n = 1'b0;
      wr(18'h000f0, 1'b0);
      wr_end();
      tick(1);
      exp_q.push_back(18'h00005);
      exp_q.push_back(18'h000f0);
      exp_q.push_back(18'h00005);
      go = 1'b1;
      tick(3);
      go = 1'b0;
      offset_load_n = 1'b1;
      for (int i = 0; i < 6; i++)
         wr(next_word(), 1'b1);
      check(almost_empty_n, 1'b0);
      wr_end();
      check(almost_empty_n, 1'b1);
      drain(1'b1);
      end_test("offsets");
      for (int i = 0; i < 258; i++)
      begin
         wr(next_word(), i < 256);
         if (i == 15 || i == 16)
            check(almost_full_n, i == 15);
      end
      wr_end();
      tick(1);
      check(full_flag_n, 1'b0);
      check(half_full_n, 1'b0);
      go = 1'b1;
      tick(4);
      check(full_flag_n, 1'b1);
      drain(1'b1);
      tick(2);
      check(empty_flag_n, 1'b0);
      check(half_full_n, 1'b1);
      go = 1'b1;
      tick(3);
      go = 1'b0;
      end_test("fill and drain");
      fall_through_mode_on = 1'b1;
      do_reset(3'b001);
      check(empty_flag_n, 1'b1);
      check(full_flag_n, 1'b0);
      w = next_word();
      wr(w, 1'b0);
      wr_end();
      tick(2);
      check(empty_flag_n, 1'b1);
      tick(1);
      check(read_data, w);
      check(empty_flag_n, 1'b0);
      offset_load_n = 1'b0;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      offset_load_n = 1'b1;
      tick(1);
      check(read_data, w);
      go = 1'b1;
      tick(1);
      go = 1'b0;
      check(empty_flag_n, 1'b1);
      check(read_data, w);
      end_test("fall through");
      complete_run();
   end

endmodule
